/* File: include/remote_io_pkg.sv */
// Constants shared by the remote I/O command bank and its mapping helpers
package remote_io_pkg;

    localparam int REG_W = 16;
    localparam int RIN_BITS = 16;
    localparam int DIN_BITS = 6;
    localparam int IN_CODE_W = 4;
    localparam int OUT_CODE_W = 5;
    localparam int IN_FUNCS = 10;
    localparam int OUT_FUNCS = 17;

    // Register addresses; even address is the upper half of a 32-bit item
    localparam logic [15:0] ADDR_GROUP_UP = 16'h0030;
    localparam logic [15:0] ADDR_GROUP_LO = 16'h0031;
    localparam logic [15:0] ADDR_INCMD_UP = 16'h007C;
    localparam logic [15:0] ADDR_INCMD_LO = 16'h007D;
    localparam logic [15:0] ADDR_OUTST_UP = 16'h007E;
    localparam logic [15:0] ADDR_OUTST_LO = 16'h007F;

    localparam logic [31:0] GROUP_RST = 32'h0000_0000;
    localparam logic [31:0] INCMD_RST = 32'h0000_0000;

    // Input function codes (index into the function vector is code - 1)
    localparam logic [3:0] IN_NONE = 4'h0;
    localparam logic [3:0] IN_SEL0 = 4'h1;
    localparam logic [3:0] IN_SEL1 = 4'h2;
    localparam logic [3:0] IN_SEL2 = 4'h3;
    localparam logic [3:0] IN_RUN_A = 4'h4;
    localparam logic [3:0] IN_RUN_B = 4'h5;
    localparam logic [3:0] IN_STYLE = 4'h6;
    localparam logic [3:0] IN_BRAKE = 4'h7;
    localparam logic [3:0] IN_SHAFT = 4'h8;
    localparam logic [3:0] IN_TOOL = 4'h9;

    // Output function codes
    localparam logic [4:0] OUT_NONE = 5'h00;
    localparam logic [4:0] OUT_RUN_A = 5'h01;
    localparam logic [4:0] OUT_RUN_B = 5'h02;
    localparam logic [4:0] OUT_STYLE = 5'h03;
    localparam logic [4:0] OUT_BRAKE = 5'h04;
    localparam logic [4:0] OUT_SHAFT = 5'h05;
    localparam logic [4:0] OUT_SEL0 = 5'h06;
    localparam logic [4:0] OUT_SEL1 = 5'h07;
    localparam logic [4:0] OUT_SEL2 = 5'h08;
    localparam logic [4:0] OUT_ALARM = 5'h09;
    localparam logic [4:0] OUT_WARN = 5'h0A;
    localparam logic [4:0] OUT_MOVE = 5'h0B;
    localparam logic [4:0] OUT_TORQUE = 5'h0C;
    localparam logic [4:0] OUT_SPEED = 5'h0D;
    localparam logic [4:0] OUT_BUSY = 5'h0E;
    localparam logic [4:0] OUT_OVLD = 5'h0F;
    localparam logic [4:0] OUT_MPWR = 5'h10;

    // Factory bit assignments, bit 0 in the lowest field
    localparam logic [63:0] IN_MAP_DEFAULT = 64'h0000_0000_7065_4321;
    localparam logic [79:0] OUT_MAP_DEFAULT = 80'h6375_E000_0399_B022_18C6;

endpackage

/* File: hdl/input_function_map.sv */
// Folds a group of input bits onto the input function vector by a code map
`timescale 1ns/1ps
module input_function_map
    import remote_io_pkg::*;
#(
    parameter int NBITS = 16
) (
    input wire logic [NBITS-1:0] bits_i,
    input wire logic [NBITS*IN_CODE_W-1:0] map_i,
    output logic [IN_FUNCS-1:0] func_o,
    output logic [IN_FUNCS-1:0] mapped_o
);

    always_comb begin
        func_o = '0;
        mapped_o = '0;
        for (int b = 0; b < NBITS; b++) begin
            for (int f = 0; f < IN_FUNCS; f++) begin
                if (map_i[b*IN_CODE_W +: IN_CODE_W] == IN_CODE_W'(f + 1)) begin
                    mapped_o[f] = 1'b1;
                    func_o[f] = func_o[f] | bits_i[b];
                end
            end
        end
    end

endmodule

/* File: hdl/output_status_map.sv */
// Places driver status functions onto the sixteen remote output bits
`timescale 1ns/1ps
module output_status_map
    import remote_io_pkg::*;
(
    input wire logic [OUT_FUNCS-1:0] status_i,
    input wire logic [RIN_BITS*OUT_CODE_W-1:0] map_i,
    output logic [RIN_BITS-1:0] bits_o
);

    logic [OUT_FUNCS:0] table_w;

    // Code zero selects a constant low
    assign table_w = {status_i, 1'b0};

    always_comb begin
        bits_o = '0;
        for (int b = 0; b < RIN_BITS; b++) begin
            if (map_i[b*OUT_CODE_W +: OUT_CODE_W] <= OUT_CODE_W'(OUT_FUNCS)) begin
                bits_o[b] = table_w[map_i[b*OUT_CODE_W +: OUT_CODE_W]];
            end
        end
    end

endmodule

/* File: hdl/remote_io_command_bank.sv */
// Remote I/O command registers and motor command decode of the driver
`timescale 1ns/1ps
module remote_io_command_bank
    import remote_io_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rstn_i,
    // Register port from the protocol engine
    input wire logic [15:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [REG_W-1:0] reg_wdata_i,
    output logic [REG_W-1:0] reg_rdata_o,
    output logic reg_ack_o,
    output logic reg_err_o,
    // Query address check
    input wire logic qry_valid_i,
    input wire logic [7:0] qry_addr_i,
    input wire logic [7:0] slave_addr_i,
    output logic qry_accept_o,
    // Configuration from the parameter store
    input wire logic three_wire_i,
    input wire logic load_hold_en_i,
    input wire logic [RIN_BITS*IN_CODE_W-1:0] remote_map_i,
    input wire logic [DIN_BITS*IN_CODE_W-1:0] direct_map_i,
    input wire logic [RIN_BITS*OUT_CODE_W-1:0] out_map_i,
    // Direct input pins, asynchronous
    input wire logic [DIN_BITS-1:0] direct_input_pins_i,
    // Driver status
    input wire logic alarm_i,
    input wire logic warning_i,
    input wire logic moving_i,
    input wire logic torque_limit_i,
    input wire logic speed_out_band_i,
    input wire logic busy_i,
    input wire logic overload_i,
    input wire logic main_power_i,
    // Motor command outputs
    output logic run_o,
    output logic dir_reverse_o,
    output logic decel_stop_o,
    output logic brake_release_on_halt_o,
    output logic shaft_free_o,
    output logic tool_unlock_o,
    output logic [2:0] op_data_sel_o
);

    function automatic logic [15:0] half_sel(input logic [31:0] word, input logic upper);
        half_sel = upper ? word[31:16] : word[15:0];
    endfunction

    // A register pair answers to both of its addresses; bit 0 is left out
    function automatic logic pair_hit(input logic [15:0] addr, input logic [15:0] base);
        pair_hit = addr[15:1] == base[15:1];
    endfunction

    logic [31:0] group_ff;
    logic [31:0] incmd_ff;
    logic [15:0] outst_ff;
    logic [15:0] nxt_outst;
    logic [REG_W-1:0] reg_rdata_ff;
    logic reg_ack_ff;
    logic reg_err_ff;
    logic qry_accept_ff;
    // Pin synchroniser stages and the accepted value
    logic [DIN_BITS-1:0] pin_s1_ff;
    logic [DIN_BITS-1:0] pin_s2_ff;
    logic [DIN_BITS-1:0] pin_s3_ff;
    logic [DIN_BITS-1:0] pin_ff;
    // Function vectors; the index is the function code minus one
    logic [IN_FUNCS-1:0] rem_func;
    logic [IN_FUNCS-1:0] rem_mapped;
    logic [IN_FUNCS-1:0] dir_func;
    logic [IN_FUNCS-1:0] dir_mapped;
    logic [IN_FUNCS-1:0] func;
    logic [OUT_FUNCS-1:0] status_vec;
    // Address and query hits
    logic hit_group;
    logic hit_incmd;
    logic hit_outst;
    logic hit_any;
    logic unmapped_acc;
    logic status_wr;
    logic own_hit;
    logic grp_hit;
    logic nxt_run;
    logic nxt_rev;
    logic nxt_decel;
    logic nxt_tool;
    logic run_ff;
    logic rev_ff;
    logic decel_ff;
    logic brake_ff;
    logic shaft_ff;
    logic tool_ff;
    logic [2:0] sel_ff;

    // Address decode; bit 0 of the address picks the half
    assign hit_group = pair_hit(reg_addr_i, ADDR_GROUP_UP);
    assign hit_incmd = pair_hit(reg_addr_i, ADDR_INCMD_UP);
    assign hit_outst = pair_hit(reg_addr_i, ADDR_OUTST_UP);
    assign hit_any = hit_group | hit_incmd | hit_outst;

    // Unmapped accesses and writes to the status pair both answer with an error
    assign unmapped_acc = (reg_rd_i | reg_wr_i) & ~hit_any;
    assign status_wr = reg_wr_i & hit_outst;

    // Group address, held in flip-flops only so power loss forgets it
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            group_ff <= GROUP_RST;
        end else if (reg_wr_i && hit_group) begin
            if (reg_addr_i[0]) begin
                group_ff[15:0] <= reg_wdata_i;
            end else begin
                group_ff[31:16] <= reg_wdata_i;
            end
        end
    end

    // Each half updates on its own write; a split update is visible in between
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            incmd_ff <= INCMD_RST;
        end else if (reg_wr_i && hit_incmd) begin
            if (reg_addr_i[0]) begin
                incmd_ff[15:0] <= reg_wdata_i;
            end else begin
                incmd_ff[31:16] <= reg_wdata_i;
            end
        end
    end

    // Read data, acknowledge and error, one cycle after the request
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reg_rdata_ff <= '0;
        end else if (reg_rd_i) begin
            if (hit_group) begin
                reg_rdata_ff <= half_sel(group_ff, ~reg_addr_i[0]);
            end else if (hit_incmd) begin
                reg_rdata_ff <= half_sel(incmd_ff, ~reg_addr_i[0]);
            end else if (hit_outst) begin
                reg_rdata_ff <= half_sel({16'h0000, outst_ff}, ~reg_addr_i[0]);
            end else begin
                reg_rdata_ff <= '0;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reg_ack_ff <= 1'b0;
            reg_err_ff <= 1'b0;
        end else begin
            reg_ack_ff <= reg_rd_i | reg_wr_i;
            // Writes to the status pair are refused, not stored
            reg_err_ff <= unmapped_acc | status_wr;
        end
    end

    // A query addressed to us or to our group is taken
    assign own_hit = qry_addr_i == slave_addr_i;
    // The whole 32-bit group value must match, so a large group number never aliases
    assign grp_hit = group_ff == {24'h000000, qry_addr_i};
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            qry_accept_ff <= 1'b0;
        end else begin
            qry_accept_ff <= qry_valid_i & (own_hit | grp_hit);
        end
    end

    // Pins are asynchronous; a change counts once stages two and three agree
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_s1_ff <= '0;
            pin_s2_ff <= '0;
            pin_s3_ff <= '0;
            pin_ff <= '0;
        end else begin
            pin_s1_ff <= direct_input_pins_i;
            pin_s2_ff <= pin_s1_ff;
            pin_s3_ff <= pin_s2_ff;
            for (int i = 0; i < DIN_BITS; i++) begin
                if (pin_s2_ff[i] == pin_s3_ff[i]) begin
                    pin_ff[i] <= pin_s3_ff[i];
                end
            end
        end
    end

    // Remote bits fold onto functions through the configured code map
    input_function_map #(
        .NBITS(RIN_BITS)
    ) u_remote_map (
        .bits_i(incmd_ff[15:0]),
        .map_i(remote_map_i),
        .func_o(rem_func),
        .mapped_o(rem_mapped)
    );

    // Direct pins share the code table of the remote bits
    input_function_map #(
        .NBITS(DIN_BITS)
    ) u_direct_map (
        .bits_i(pin_ff),
        .map_i(direct_map_i),
        .func_o(dir_func),
        .mapped_o(dir_mapped)
    );

    // Remote and direct sources combine by OR; tool unlock has its own rule
    assign func = rem_func | dir_func;

    // Unlock stays open by default so a unit with no tool input remains usable
    always_comb begin
        if (rem_mapped[IN_TOOL-1] && dir_mapped[IN_TOOL-1]) begin
            nxt_tool = rem_func[IN_TOOL-1] & dir_func[IN_TOOL-1];
        end else if (rem_mapped[IN_TOOL-1] || dir_mapped[IN_TOOL-1]) begin
            nxt_tool = func[IN_TOOL-1];
        end else begin
            nxt_tool = 1'b1;
        end
    end

    // Run decode for both input modes
    always_comb begin
        if (three_wire_i) begin
            nxt_run = func[IN_RUN_A-1] & func[IN_RUN_B-1];
            nxt_rev = func[IN_STYLE-1];
            // Coast-halt low forces the instantaneous stop even if run is also low
            nxt_decel = func[IN_RUN_B-1];
        end else begin
            // Both directions at once is treated as a stop
            nxt_run = func[IN_RUN_A-1] ^ func[IN_RUN_B-1];
            // Reverse needs the backward bit alone
            nxt_rev = func[IN_RUN_B-1] & ~func[IN_RUN_A-1];
            nxt_decel = func[IN_STYLE-1];
        end
    end

    // Command outputs lag the register write by one cycle
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            run_ff <= 1'b0;
            rev_ff <= 1'b0;
            decel_ff <= 1'b0;
        end else begin
            run_ff <= nxt_run;
            rev_ff <= nxt_rev;
            decel_ff <= nxt_decel;
        end
    end

    // Standstill features only act while the motor is not turning
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            brake_ff <= 1'b0;
            shaft_ff <= 1'b0;
        end else begin
            brake_ff <= func[IN_BRAKE-1] & ~moving_i;
            shaft_ff <= load_hold_en_i & ~moving_i & func[IN_SHAFT-1];
        end
    end

    // The select index follows the combined inputs one cycle later
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tool_ff <= 1'b0;
            sel_ff <= 3'h0;
        end else begin
            tool_ff <= nxt_tool;
            sel_ff <= {func[IN_SEL2-1], func[IN_SEL1-1], func[IN_SEL0-1]};
        end
    end

    // Status vector in output code order, code 1 at index 0
    // The top entry is a spare code that always reads low
    assign status_vec = {1'b0, main_power_i, overload_i, busy_i, speed_out_band_i, torque_limit_i,
                         moving_i, warning_i, alarm_i,
                         func[IN_SEL2-1], func[IN_SEL1-1], func[IN_SEL0-1],
                         func[IN_SHAFT-1], func[IN_BRAKE-1], func[IN_STYLE-1],
                         func[IN_RUN_B-1], func[IN_RUN_A-1]};

    output_status_map u_out_map (
        .status_i(status_vec),
        .map_i(out_map_i),
        .bits_o(nxt_outst)
    );

    // Registered so a read sees one snapshot of all sixteen bits
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            outst_ff <= 16'h0000;
        end else begin
            outst_ff <= nxt_outst;
        end
    end

    // Outputs come straight from the flip-flops above
    assign reg_rdata_o = reg_rdata_ff;
    assign reg_ack_o = reg_ack_ff;
    assign reg_err_o = reg_err_ff;
    assign qry_accept_o = qry_accept_ff;
    assign run_o = run_ff;
    assign dir_reverse_o = rev_ff;
    assign decel_stop_o = decel_ff;
    assign brake_release_on_halt_o = brake_ff;
    assign shaft_free_o = shaft_ff;
    assign tool_unlock_o = tool_ff;
    assign op_data_sel_o = sel_ff;

endmodule

/* File: verif/remote_io_checker.sv */
// Port-level assertions for the remote I/O command bank
`timescale 1ns/1ps
module remote_io_checker
    import remote_io_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [REG_W-1:0] reg_wdata_i,
    input wire logic reg_ack_o,
    input wire logic reg_err_o,
    input wire logic qry_valid_i,
    input wire logic [7:0] qry_addr_i,
    input wire logic [7:0] slave_addr_i,
    input wire logic qry_accept_o,
    input wire logic three_wire_i,
    input wire logic [RIN_BITS*IN_CODE_W-1:0] remote_map_i,
    input wire logic [DIN_BITS*IN_CODE_W-1:0] direct_map_i,
    input wire logic run_o,
    input wire logic dir_reverse_o,
    input wire logic decel_stop_o,
    input wire logic [2:0] op_data_sel_o
);
    logic wr2_ff;
    logic wr3_ff;
    logic [15:0] cmd_ff;
    // Decode checks only hold for the factory map with no direct pins mapped
    wire cmd_wr = reg_wr_i && reg_addr_i == ADDR_INCMD_LO && remote_map_i == IN_MAP_DEFAULT && direct_map_i == '0;
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr2_ff <= 1'b0;
            wr3_ff <= 1'b0;
            cmd_ff <= '0;
        end else begin
            wr2_ff <= cmd_wr && !three_wire_i;
            wr3_ff <= cmd_wr && three_wire_i;
            cmd_ff <= reg_wdata_i;
        end
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    ack_follows_req_a: assert property ((reg_wr_i || reg_rd_i) |=> reg_ack_o)
        else $error("access not acknowledged");
    ack_needs_req_a: assert property (!(reg_wr_i || reg_rd_i) |=> !reg_ack_o)
        else $error("ack without access");
    status_write_err_a: assert property
        (reg_wr_i && (reg_addr_i == ADDR_OUTST_UP || reg_addr_i == ADDR_OUTST_LO) |=> reg_ack_o && reg_err_o)
        else $error("status write not refused");
    status_read_ok_a: assert property (reg_rd_i && reg_addr_i == ADDR_OUTST_LO |=> !reg_err_o)
        else $error("status read refused");
    two_wire_run_a: assert property (wr2_ff |=> run_o == ($past(cmd_ff[3]) ^ $past(cmd_ff[4]))
        && (!run_o || dir_reverse_o == $past(cmd_ff[4]))) else $error("two-wire run wrong");
    stop_style_a: assert property (wr2_ff |=> decel_stop_o == $past(cmd_ff[5]))
        else $error("stop style wrong");
    three_wire_run_a: assert property (wr3_ff |=> run_o == ($past(cmd_ff[3]) && $past(cmd_ff[4]))
        && (!run_o || dir_reverse_o == $past(cmd_ff[5]))) else $error("three-wire run wrong");
    coast_halt_a: assert property (wr3_ff |=> decel_stop_o == $past(cmd_ff[4]))
        else $error("three-wire stop kind wrong");
    op_select_a: assert property ((wr2_ff || wr3_ff) |=> op_data_sel_o == $past(cmd_ff[2:0]))
        else $error("data select wrong");
    own_query_a: assert property (qry_valid_i && qry_addr_i == slave_addr_i |=> qry_accept_o)
        else $error("own query missed");
    query_needed_a: assert property (!qry_valid_i |=> !qry_accept_o)
        else $error("accept without query");
    cover property (reg_ack_o && reg_err_o);
    cover property (wr3_ff ##1 run_o);
    cover property (qry_accept_o);
endmodule

/* File: verif/modbus_master_model.sv */
// Register-port master standing in for the protocol engine
`timescale 1ns/1ps
module modbus_master_model
    import remote_io_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reg_ack_i,
    input wire logic reg_err_i,
    input wire logic [REG_W-1:0] reg_rdata_i,
    input wire logic qry_accept_i,
    output logic [15:0] reg_addr_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [REG_W-1:0] reg_wdata_o,
    output logic qry_valid_o,
    output logic [7:0] qry_addr_o
);
    initial begin
        reg_addr_o = 16'hFFFF;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_wdata_o = 16'h5A5A;
        qry_valid_o = 1'b0;
        qry_addr_o = 8'hA5;
    end
    // Strobe is a one-cycle pulse; the answer stands in the cycle after it
    task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] d,
                          output logic [15:0] rd, output logic [1:0] resp);
        @(posedge core_clk_i);
        #1;
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_wr_o = wr;
        reg_rd_o = !wr;
        @(posedge core_clk_i);
        #1;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        // Released lines show garbage so stale values cannot pass
        reg_addr_o = ~a;
        reg_wdata_o = ~d;
        rd = reg_rdata_i;
        resp = {reg_ack_i, reg_err_i};
    endtask
    task automatic write32(input logic [15:0] a, input logic [31:0] d);
        logic [15:0] rd;
        logic [1:0] resp;
        access(1'b1, a, d[31:16], rd, resp);
        access(1'b1, a | 16'h0001, d[15:0], rd, resp);
    endtask
    task automatic query(input logic [7:0] a, output logic acc);
        @(posedge core_clk_i);
        #1;
        qry_valid_o = 1'b1;
        qry_addr_o = a;
        @(posedge core_clk_i);
        #1;
        qry_valid_o = 1'b0;
        qry_addr_o = ~a;
        acc = qry_accept_i;
    endtask
endmodule

/* File: verif/tb_top.sv */
// Self-checking bench for the remote I/O command bank
`timescale 1ns/1ps
module tb_top;
    import remote_io_pkg::*;
    logic core_clk_i, rstn_i, reg_wr_i, reg_rd_i, reg_ack_o, reg_err_o, qry_valid_i, qry_accept_o, acc;
    logic [15:0] reg_addr_i, reg_wdata_i, reg_rdata_o, rd;
    logic [7:0] qry_addr_i;
    logic [7:0] slave_addr_i = 8'h05;
    logic three_wire_i, load_hold_en_i, alarm_i, warning_i, moving_i, busy_i;
    logic [63:0] remote_map_i;
    logic [23:0] direct_map_i;
    logic [79:0] out_map_i;
    logic [5:0] direct_input_pins_i;
    logic run_o, dir_reverse_o, decel_stop_o, brake_release_on_halt_o, shaft_free_o, tool_unlock_o;
    logic [2:0] op_data_sel_o;
    logic [1:0] resp;
    int err_total = 0;
    int n_checks = 0;
    localparam logic [15:0] RST_ADRS [4] = '{ADDR_GROUP_UP, ADDR_GROUP_LO, ADDR_INCMD_UP, ADDR_INCMD_LO};
    localparam logic [15:0] T2 [6] = '{16'h0008, 16'h0010, 16'h0018, 16'h0028, 16'h0085, 16'h0000};
    localparam logic [15:0] T3 [6] = '{16'h0018, 16'h0038, 16'h0010, 16'h0008, 16'h0000, 16'h0007};
    remote_io_command_bank u_remote_io_command_bank (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
        .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .reg_ack_o(reg_ack_o), .reg_err_o(reg_err_o), .qry_valid_i(qry_valid_i),
        .qry_addr_i(qry_addr_i), .slave_addr_i(slave_addr_i), .qry_accept_o(qry_accept_o),
        .three_wire_i(three_wire_i), .load_hold_en_i(load_hold_en_i), .remote_map_i(remote_map_i),
        .direct_map_i(direct_map_i), .out_map_i(out_map_i), .direct_input_pins_i(direct_input_pins_i),
        .alarm_i(alarm_i), .warning_i(warning_i), .moving_i(moving_i), .torque_limit_i(1'b0),
        .speed_out_band_i(1'b0), .busy_i(busy_i), .overload_i(1'b0), .main_power_i(1'b0), .run_o(run_o),
        .dir_reverse_o(dir_reverse_o), .decel_stop_o(decel_stop_o),
        .brake_release_on_halt_o(brake_release_on_halt_o), .shaft_free_o(shaft_free_o),
        .tool_unlock_o(tool_unlock_o), .op_data_sel_o(op_data_sel_o));
    modbus_master_model u_modbus_master_model (.core_clk_i(core_clk_i), .reg_ack_i(reg_ack_o),
        .reg_err_i(reg_err_o), .reg_rdata_i(reg_rdata_o), .qry_accept_i(qry_accept_o), .reg_addr_o(reg_addr_i),
        .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_wdata_o(reg_wdata_i), .qry_valid_o(qry_valid_i),
        .qry_addr_o(qry_addr_i));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic rdchk(input logic [15:0] a, input logic [15:0] exp, input logic er);
        u_modbus_master_model.access(1'b0, a, 16'h0000, rd, resp);
        chk(rd, exp);
        chk({14'h0, resp}, {14'h0, 1'b1, er});
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic er);
        u_modbus_master_model.access(1'b1, a, d, rd, resp);
        chk({14'h0, resp}, {14'h0, 1'b1, er});
    endtask
    // Direction is only meaningful while running, so it is masked by run
    function automatic logic [15:0] outs();
        return {9'h0, run_o, run_o & dir_reverse_o, decel_stop_o, brake_release_on_halt_o, op_data_sel_o};
    endfunction
    function automatic logic [15:0] e2(input logic [15:0] d);
        return {9'h0, d[3] ^ d[4], (d[3] ^ d[4]) & d[4], d[5], d[7], d[2:0]};
    endfunction
    function automatic logic [15:0] e3(input logic [15:0] d);
        return {9'h0, d[3] & d[4], d[3] & d[4] & d[5], d[4], d[7], d[2:0]};
    endfunction
    task automatic cmd(input logic [15:0] d, input logic [15:0] exp);
        wr(ADDR_INCMD_LO, d, 1'b0);
        @(posedge core_clk_i);
        #1;
        chk(outs(), exp);
    endtask
    initial begin
        core_clk_i = 1'b0;
        forever #4 core_clk_i = ~core_clk_i;
    end
    initial begin
        repeat (20000) @(posedge core_clk_i);
        err_total++;
        conclude();
    end
    initial begin
        rstn_i = 1'b0;
        three_wire_i = 1'b0;
        load_hold_en_i = 1'b0;
        alarm_i = 1'b1;
        warning_i = 1'b1;
        moving_i = 1'b0;
        busy_i = 1'b0;
        remote_map_i = IN_MAP_DEFAULT;
        direct_map_i = '0;
        direct_input_pins_i = '0;
        out_map_i = {60'h0, OUT_RUN_A, OUT_WARN, OUT_BUSY, OUT_ALARM};
        repeat (20) @(posedge core_clk_i);
        #1;
        rstn_i = 1'b1;
        for (int i = 0; i < 4; i++) rdchk(RST_ADRS[i], 16'h0000, 1'b0);
        chk({15'h0, tool_unlock_o}, 16'h0001);
        u_modbus_master_model.write32(ADDR_GROUP_UP, 32'h0000_0022);
        rdchk(ADDR_GROUP_UP, 16'h0000, 1'b0);
        rdchk(ADDR_GROUP_LO, 16'h0022, 1'b0);
        wr(ADDR_INCMD_UP, 16'hA5C3, 1'b0);
        rdchk(ADDR_INCMD_UP, 16'hA5C3, 1'b0);
        u_modbus_master_model.query(8'h22, acc);
        chk({15'h0, acc}, 16'h0001);
        u_modbus_master_model.query(8'h05, acc);
        chk({15'h0, acc}, 16'h0001);
        u_modbus_master_model.query(8'h23, acc);
        chk({15'h0, acc}, 16'h0000);
        wr(ADDR_OUTST_LO, 16'hFFFF, 1'b1);
        rdchk(ADDR_OUTST_LO, 16'h0005, 1'b0);
        rdchk(ADDR_OUTST_UP, 16'h0000, 1'b0);
        rdchk(16'h0040, 16'h0000, 1'b1);
        alarm_i = 1'b0;
        busy_i = 1'b1;
        cmd(16'h0008, e2(16'h0008));
        rdchk(ADDR_OUTST_LO, 16'h000E, 1'b0);
        for (int i = 0; i < 6; i++) cmd(T2[i], e2(T2[i]));
        three_wire_i = 1'b1;
        for (int i = 0; i < 6; i++) cmd(T3[i], e3(T3[i]));
        three_wire_i = 1'b0;
        load_hold_en_i = 1'b1;
        remote_map_i = IN_MAP_DEFAULT | (64'(IN_RUN_A) << 36) | (64'(IN_TOOL) << 40) | (64'(IN_SHAFT) << 44);
        cmd(16'h0200, 16'h0040);
        chk({15'h0, tool_unlock_o}, 16'h0000);
        cmd(16'h0C00, 16'h0000);
        chk({15'h0, tool_unlock_o}, 16'h0001);
        chk({15'h0, shaft_free_o}, 16'h0001);
        direct_map_i = {16'h0000, IN_TOOL, IN_RUN_A};
        repeat (6) @(posedge core_clk_i);
        #1;
        chk({15'h0, tool_unlock_o}, 16'h0000);
        direct_input_pins_i = 6'b000011;
        repeat (6) @(posedge core_clk_i);
        #1;
        chk({15'h0, tool_unlock_o}, 16'h0001);
        chk({15'h0, run_o}, 16'h0001);
        rstn_i = 1'b0;
        repeat (2) @(posedge core_clk_i);
        #1;
        rstn_i = 1'b1;
        chk({15'h0, run_o}, 16'h0000);
        rdchk(ADDR_INCMD_LO, 16'h0000, 1'b0);
        conclude();
    end
endmodule
bind remote_io_command_bank remote_io_checker u_remote_io_checker (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
    .reg_ack_o(reg_ack_o), .reg_err_o(reg_err_o), .qry_valid_i(qry_valid_i), .qry_addr_i(qry_addr_i),
    .slave_addr_i(slave_addr_i), .qry_accept_o(qry_accept_o), .three_wire_i(three_wire_i),
    .remote_map_i(remote_map_i), .direct_map_i(direct_map_i), .run_o(run_o), .dir_reverse_o(dir_reverse_o),
    .decel_stop_o(decel_stop_o), .op_data_sel_o(op_data_sel_o));
